// [hdl/dcsm_core.sv]
// drive command word decode, state word build and operating-mode switching
`timescale 1ns/1ps

// Summary of operation
// - bits 0,1,3 are switch-on, voltage, operation requests
// - fault reset on bit 7 rising edge only
// - bit 7 held high blocks other commands
// - bit 8 passed as halt request
// - state bits 0-3 prepared, switched, enabled, fault
// - state bits 4,5,6,7,9,10,11,15 report drive flags
// - selector 1,3,4,6 decode pp, pv, pt, homing
// - selector 8,9,10 decode cyclic position/velocity/torque
// - leaving position modes flushes pending position commands
// - leaving velocity/torque modes ramps to stop first
// - no mode change while homing runs
// - drive failure forces fault shutdown pattern unless the drive already reports a fault
module dcsm_core
    import dcsm_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_reg_wr,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    input  wire dcsm_flags_t i_flags,
    input  wire logic        i_drive_failure,
    input  wire logic        i_homing_active,
    input  wire logic        i_stop_done,
    output dcsm_req_t        o_req,
    output dcsm_mode_t       o_active_mode,
    output logic             o_flush_pos,
    output logic             o_ramp_stop,
    output logic             o_mode_busy,
    output logic             o_fault_shutdown,
    output logic      [15:0] o_state_word
);

    dcsm_state_t st_reg;
    dcsm_state_t st_next;

    function automatic dcsm_mode_t decode_mode(input logic [7:0] sel);
        dcsm_mode_t m;
        m = DCSM_MODE_IDLE;
        case (sel)
            DCSM_MODE_PP:  m = DCSM_PROFILE_POSITION_MODE;
            DCSM_MODE_PV:  m = DCSM_PROFILE_VELOCITY_MODE;
            DCSM_MODE_PT:  m = DCSM_PROFILE_TORQUE_MODE;
            DCSM_MODE_HM:  m = DCSM_HOMING_MODE;
            DCSM_MODE_CSP: m = DCSM_CYC_POS_MODE;
            DCSM_MODE_CSV: m = DCSM_CYC_VEL_MODE;
            DCSM_MODE_CST: m = DCSM_CYC_TRQ_MODE;
            default:       m = DCSM_MODE_IDLE;
        endcase
        return m;
    endfunction : decode_mode

    function automatic logic is_pos_mode(input dcsm_mode_t m);
        return (m == DCSM_PROFILE_POSITION_MODE) || (m == DCSM_CYC_POS_MODE);
    endfunction : is_pos_mode

    function automatic logic needs_ramp(input dcsm_mode_t m);
        return (m == DCSM_PROFILE_VELOCITY_MODE) || (m == DCSM_PROFILE_TORQUE_MODE)
            || (m == DCSM_CYC_VEL_MODE) || (m == DCSM_CYC_TRQ_MODE);
    endfunction : needs_ramp

    logic        cmd_wr;
    logic        mode_wr;
    logic [15:0] cw;
    logic        fr_rise;
    logic        fr_hold;
    dcsm_mode_t  want;

    assign cmd_wr  = i_reg_wr && (i_reg_addr == DCSM_CMD_WORD_OFS);
    assign mode_wr = i_reg_wr && (i_reg_addr == DCSM_MODE_SEL_OFS);
    assign cw      = st_reg.cmd_word;
    assign fr_rise = cw[DCSM_CB_FAULT_RST] && !st_reg.fr_prev;
    assign fr_hold = cw[DCSM_CB_FAULT_RST] && st_reg.fr_prev;
    assign want    = decode_mode(st_reg.mode_sel);

    always_comb begin
        st_next = st_reg;
        st_next.flush_pos = 1'b0;
        if (cmd_wr) begin
            st_next.cmd_word = i_reg_wdata;
        end
        if (mode_wr) begin
            st_next.mode_sel = i_reg_wdata[7:0];
        end
        st_next.fr_prev = cw[DCSM_CB_FAULT_RST];

        // held reset bit masks every other command
        if (fr_hold) begin
            st_next.req.switch_on        = 1'b0;
            st_next.req.enable_voltage   = 1'b0;
            st_next.req.quick_stop       = 1'b0;
            st_next.req.enable_operation = 1'b0;
            st_next.req.halt             = 1'b0;
            st_next.req.mode_bits        = 4'h0;
        end else begin
            st_next.req.switch_on        = cw[DCSM_CB_SWITCH_ON];
            st_next.req.enable_voltage   = cw[DCSM_CB_ENABLE_VOLT];
            st_next.req.quick_stop       = cw[DCSM_CB_QUICK_STOP];
            st_next.req.enable_operation = cw[DCSM_CB_ENABLE_OP];
            st_next.req.halt             = cw[DCSM_CB_HALT];
            st_next.req.mode_bits        = {cw[DCSM_CB_MS9], cw[DCSM_CB_MS_HI:DCSM_CB_MS_LO]};
        end
        // one-cycle pulse; resettable classing is the fault logic's job
        st_next.req.fault_reset = fr_rise;

        // failure latches until the reset edge clears it
        if (i_drive_failure && !i_flags.fault) begin
            st_next.fault_shutdown = 1'b1;
        end else if (fr_rise) begin
            st_next.fault_shutdown = 1'b0;
        end

        case (st_reg.sw)
            DCSM_SW_STEADY: begin
                if (want != st_reg.active_mode && !i_homing_active) begin
                    if (is_pos_mode(st_reg.active_mode)) begin
                        st_next.flush_pos = 1'b1;
                    end
                    if (needs_ramp(st_reg.active_mode)) begin
                        st_next.pending_mode = want;
                        st_next.ramp_stop    = 1'b1;
                        st_next.sw           = DCSM_SW_RAMP;
                    end else begin
                        st_next.active_mode = want;
                    end
                end
            end
            DCSM_SW_RAMP: begin
                // new mode applies only once the ramp has ended
                if (i_stop_done) begin
                    st_next.active_mode = st_reg.pending_mode;
                    st_next.ramp_stop   = 1'b0;
                    st_next.sw          = DCSM_SW_STEADY;
                end
            end
            default: begin
                st_next.sw = DCSM_SW_STEADY;
            end
        endcase

        st_next.state_word = 16'h0000;
        st_next.state_word[DCSM_SB_PREPARED] = i_flags.prepared;
        st_next.state_word[DCSM_SB_SWITCHED] = i_flags.switched_on;
        st_next.state_word[DCSM_SB_OP_EN]    = i_flags.op_enabled;
        st_next.state_word[DCSM_SB_FAULT]    = i_flags.fault;
        st_next.state_word[DCSM_SB_VOLT]     = i_flags.voltage_on;
        st_next.state_word[DCSM_SB_QSTOP]    = i_flags.quick_stop;
        st_next.state_word[DCSM_SB_SO_DIS]   = i_flags.switch_on_disabled;
        st_next.state_word[DCSM_SB_WARN]     = i_flags.warning;
        st_next.state_word[DCSM_SB_REMOTE]   = i_flags.remote;
        st_next.state_word[DCSM_SB_TARGET]   = i_flags.target_reached;
        st_next.state_word[DCSM_SB_LIMIT]    = i_flags.limit_active;
        st_next.state_word[DCSM_SB_MS_LO +: 2] = i_flags.mode_status;
        st_next.state_word[DCSM_SB_HOME]     = i_flags.home_found;
        if (st_next.fault_shutdown) begin
            st_next.state_word[9:0] = DCSM_FAULT_SHUTDOWN_PAT[9:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        case (i_reg_addr)
            DCSM_CMD_WORD_OFS:   o_reg_rdata = st_reg.cmd_word;
            DCSM_STATE_WORD_OFS: o_reg_rdata = st_reg.state_word;
            DCSM_MODE_SEL_OFS:   o_reg_rdata = {8'h00, st_reg.mode_sel};
            default:             o_reg_rdata = 16'h0000;
        endcase
    end

    assign o_req            = st_reg.req;
    assign o_active_mode    = st_reg.active_mode;
    assign o_flush_pos      = st_reg.flush_pos;
    assign o_ramp_stop      = st_reg.ramp_stop;
    assign o_mode_busy      = (st_reg.sw == DCSM_SW_RAMP) || i_homing_active;
    assign o_fault_shutdown = st_reg.fault_shutdown;
    assign o_state_word     = st_reg.state_word;

    property p_fr_pulse;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_req.fault_reset |=> !o_req.fault_reset;
    endproperty
    a_fr_pulse: assert property (p_fr_pulse) else $error("fault reset not a pulse");

    property p_hold_masks;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        fr_hold |=> !o_req.switch_on && !o_req.enable_operation && !o_req.halt;
    endproperty
    a_hold_masks: assert property (p_hold_masks) else $error("held reset did not mask");

    property p_switch_on;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !fr_hold |=> o_req.switch_on == $past(cw[0]);
    endproperty
    a_switch_on: assert property (p_switch_on) else $error("switch-on decode wrong");

    property p_zero_bits;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_state_word[8] == 1'b0 && o_state_word[14] == 1'b0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("bits 8/14 not zero");

    property p_fault_pat;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_fault_shutdown |-> o_state_word[9:0] == 10'h21F;
    endproperty
    a_fault_pat: assert property (p_fault_pat) else $error("fault pattern wrong");

    property p_fault_entry;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_drive_failure && !i_flags.fault |=> o_fault_shutdown;
    endproperty
    a_fault_entry: assert property (p_fault_entry) else $error("no fault shutdown");

    property p_homing_hold;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_homing_active && st_reg.sw == DCSM_SW_STEADY |=> $stable(o_active_mode);
    endproperty
    a_homing_hold: assert property (p_homing_hold) else $error("mode changed while homing");

    property p_ramp_first;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_ramp_stop && !i_stop_done |=> $stable(o_active_mode);
    endproperty
    a_ramp_first: assert property (p_ramp_first) else $error("mode applied before stop");

    property p_flush_src;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_flush_pos |-> is_pos_mode($past(o_active_mode)) && (o_active_mode != $past(o_active_mode));
    endproperty
    a_flush_src: assert property (p_flush_src) else $error("flush without leaving position mode");

    property p_rise_reset;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(cw[DCSM_CB_FAULT_RST]) |=> o_req.fault_reset;
    endproperty
    a_rise_reset: assert property (p_rise_reset) else $error("rising reset bit gave no pulse");

    property p_enable_decode;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !fr_hold |=> o_req.enable_voltage == $past(cw[DCSM_CB_ENABLE_VOLT])
            && o_req.enable_operation == $past(cw[DCSM_CB_ENABLE_OP]);
    endproperty
    a_enable_decode: assert property (p_enable_decode) else $error("enable requests decode wrong");

    property p_halt_decode;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !fr_hold |=> o_req.halt == $past(cw[DCSM_CB_HALT]);
    endproperty
    a_halt_decode: assert property (p_halt_decode) else $error("halt request decode wrong");

    property p_mode_bits;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !fr_hold |=> o_req.mode_bits == $past({cw[DCSM_CB_MS9], cw[DCSM_CB_MS_HI:DCSM_CB_MS_LO]});
    endproperty
    a_mode_bits: assert property (p_mode_bits) else $error("mode specific bits not passed");

    property p_state_low;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !o_fault_shutdown |-> o_state_word[3:0]
            == $past({i_flags.fault, i_flags.op_enabled, i_flags.switched_on, i_flags.prepared});
    endproperty
    a_state_low: assert property (p_state_low) else $error("low state flags wrong");

    // fault pattern covers bits 9:0, so only the upper flags are free of it
    property p_state_high;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_state_word[15] == $past(i_flags.home_found)
            && o_state_word[11:10] == $past({i_flags.limit_active, i_flags.target_reached});
    endproperty
    a_state_high: assert property (p_state_high) else $error("upper state flags wrong");

    property p_ramp_apply;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_ramp_stop && i_stop_done |=> !o_ramp_stop;
    endproperty
    a_ramp_apply: assert property (p_ramp_apply) else $error("ramp not ended after stop");

    property p_flush_leave;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        is_pos_mode($past(o_active_mode)) && !is_pos_mode(o_active_mode) |-> o_flush_pos;
    endproperty
    a_flush_leave: assert property (p_flush_leave) else $error("position commands not flushed");

    property p_cyc_mode;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_reg.mode_sel == DCSM_MODE_CSV && st_reg.sw == DCSM_SW_STEADY && !i_homing_active
            && !needs_ramp(o_active_mode) |=> o_active_mode == DCSM_CYC_VEL_MODE;
    endproperty
    a_cyc_mode: assert property (p_cyc_mode) else $error("cyclic velocity decode wrong");

    c_fault_reset: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_req.fault_reset);
    c_ramp_switch: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_ramp_stop ##[1:20] !o_ramp_stop);
    c_flush:       cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_flush_pos);
    c_fault_sd:    cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_fault_shutdown);
    c_home_refuse: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) i_homing_active && want != o_active_mode);

endmodule : dcsm_core

// [hdl/dcsm_pkg.sv]
// package: constants, enums and carrier structs for the drive control/status/mode block
package dcsm_pkg;

    localparam logic [15:0] DCSM_CMD_WORD_OFS   = 16'h6040;
    localparam logic [15:0] DCSM_STATE_WORD_OFS = 16'h6041;
    localparam logic [15:0] DCSM_MODE_SEL_OFS   = 16'h6060;

    // command word bit positions
    localparam int DCSM_CB_SWITCH_ON   = 0;
    localparam int DCSM_CB_ENABLE_VOLT = 1;
    localparam int DCSM_CB_QUICK_STOP  = 2;
    localparam int DCSM_CB_ENABLE_OP   = 3;
    localparam int DCSM_CB_FAULT_RST   = 7;
    localparam int DCSM_CB_HALT        = 8;
    localparam int DCSM_CB_MS_LO       = 4;
    localparam int DCSM_CB_MS_HI       = 6;
    localparam int DCSM_CB_MS9         = 9;

    // state word bit positions
    localparam int DCSM_SB_PREPARED   = 0;
    localparam int DCSM_SB_SWITCHED   = 1;
    localparam int DCSM_SB_OP_EN      = 2;
    localparam int DCSM_SB_FAULT      = 3;
    localparam int DCSM_SB_VOLT       = 4;
    localparam int DCSM_SB_QSTOP      = 5;
    localparam int DCSM_SB_SO_DIS     = 6;
    localparam int DCSM_SB_WARN       = 7;
    localparam int DCSM_SB_REMOTE     = 9;
    localparam int DCSM_SB_TARGET     = 10;
    localparam int DCSM_SB_LIMIT      = 11;
    localparam int DCSM_SB_MS_LO      = 12;
    localparam int DCSM_SB_HOME       = 15;

    localparam logic [15:0] DCSM_FAULT_SHUTDOWN_PAT = 16'h021F;
    localparam logic [9:0]  DCSM_LOW_MASK          = 10'h3FF;

    // mode selector codes
    localparam logic [7:0] DCSM_MODE_NONE = 8'h00;
    localparam logic [7:0] DCSM_MODE_PP   = 8'h01;
    localparam logic [7:0] DCSM_MODE_PV   = 8'h03;
    localparam logic [7:0] DCSM_MODE_PT   = 8'h04;
    localparam logic [7:0] DCSM_MODE_HM   = 8'h06;
    localparam logic [7:0] DCSM_MODE_CSP  = 8'h08;
    localparam logic [7:0] DCSM_MODE_CSV  = 8'h09;
    localparam logic [7:0] DCSM_MODE_CST  = 8'h0A;

    localparam logic [15:0] DCSM_CMD_RESET  = 16'h0000;
    localparam logic [7:0]  DCSM_MODE_RESET = 8'h00;

    // master's settle time after entering a cyclic mode while running
    localparam int DCSM_CYC_SETTLE_US  = 1000;
    localparam int DCSM_CLK_MHZ        = 250;
    localparam int DCSM_CYC_SETTLE_CYC = DCSM_CYC_SETTLE_US * DCSM_CLK_MHZ;

    typedef enum logic [3:0] {
        DCSM_MODE_IDLE,
        DCSM_PROFILE_POSITION_MODE,
        DCSM_PROFILE_VELOCITY_MODE,
        DCSM_PROFILE_TORQUE_MODE,
        DCSM_HOMING_MODE,
        DCSM_CYC_POS_MODE,
        DCSM_CYC_VEL_MODE,
        DCSM_CYC_TRQ_MODE
    } dcsm_mode_t;

    typedef enum logic [1:0] {
        DCSM_SW_STEADY,
        DCSM_SW_RAMP
    } dcsm_sw_t;

    // decoded requests toward the state-transition logic
    typedef struct packed {
        logic       switch_on;
        logic       enable_voltage;
        logic       quick_stop;
        logic       enable_operation;
        logic       fault_reset;
        logic       halt;
        logic [3:0] mode_bits;
    } dcsm_req_t;

    // flags returned by the drive
    typedef struct packed {
        logic       prepared;
        logic       switched_on;
        logic       op_enabled;
        logic       fault;
        logic       voltage_on;
        logic       quick_stop;
        logic       switch_on_disabled;
        logic       warning;
        logic       remote;
        logic       target_reached;
        logic       limit_active;
        logic [1:0] mode_status;
        logic       home_found;
    } dcsm_flags_t;

    typedef struct packed {
        logic [15:0] cmd_word;
        logic [7:0]  mode_sel;
        logic        fr_prev;
        dcsm_req_t   req;
        dcsm_mode_t  active_mode;
        dcsm_mode_t  pending_mode;
        dcsm_sw_t    sw;
        logic        flush_pos;
        logic        ramp_stop;
        logic        fault_shutdown;
        logic [15:0] state_word;
    } dcsm_state_t;

endpackage : dcsm_pkg

// [dv/dcsm_drive_model.sv]
// back-end drive model: ramp-stop completion and homing run
`timescale 1ns/1ps
module dcsm_drive_model
    import dcsm_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ramp_stop,
    input  wire dcsm_mode_t i_active_mode,
    input  wire logic       i_homing_run,
    input  wire logic [7:0] i_stop_delay,
    output logic            o_stop_done,
    output logic            o_homing_active
);
    logic [7:0] ramp_cnt_reg;

    // stop completes a programmable number of cycles into the ramp, as one pulse
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ramp_cnt_reg <= 8'h00;
            o_stop_done  <= 1'b0;
        end else if (i_ramp_stop && !o_stop_done) begin
            ramp_cnt_reg <= ramp_cnt_reg + 8'h01;
            o_stop_done  <= (ramp_cnt_reg >= i_stop_delay);
        end else begin
            ramp_cnt_reg <= 8'h00;
            o_stop_done  <= 1'b0;
        end
    end

    // a homing run only exists while the block sits in homing mode
    assign o_homing_active = i_homing_run && (i_active_mode == DCSM_HOMING_MODE);
endmodule : dcsm_drive_model

// [dv/tb.sv]
// self-checking testbench for the drive command/state/mode block
`timescale 1ns/1ps
module tb;
    import dcsm_pkg::*;
    logic        i_core_clk;
    logic        i_rst_n;
    logic        i_reg_wr;
    logic [15:0] i_reg_addr;
    logic [15:0] i_reg_wdata;
    logic [15:0] o_reg_rdata;
    dcsm_flags_t i_flags;
    logic        i_drive_failure;
    logic        i_homing_active;
    logic        i_stop_done;
    dcsm_req_t   o_req;
    dcsm_mode_t  o_active_mode;
    logic        o_flush_pos;
    logic        o_ramp_stop;
    logic        o_mode_busy;
    logic        o_fault_shutdown;
    logic [15:0] o_state_word;
    logic        homing_run;
    logic [7:0]  stop_delay;
    logic [15:0] rdat;
    int          errors;
    int          cmp_count;
    int          cycles;

    dcsm_core dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_flags(i_flags), .i_drive_failure(i_drive_failure),
        .i_homing_active(i_homing_active), .i_stop_done(i_stop_done), .o_req(o_req), .o_active_mode(o_active_mode),
        .o_flush_pos(o_flush_pos), .o_ramp_stop(o_ramp_stop), .o_mode_busy(o_mode_busy),
        .o_fault_shutdown(o_fault_shutdown), .o_state_word(o_state_word));
    dcsm_drive_model drive_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ramp_stop(o_ramp_stop),
        .i_active_mode(o_active_mode), .i_homing_run(homing_run), .i_stop_delay(stop_delay),
        .o_stop_done(i_stop_done), .o_homing_active(i_homing_active));

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // the whole run needs under two hundred cycles; this only cuts a hang
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("[ERR] timeout expected end seen hang");
            test_done();
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        tick(1);
        i_reg_wr    = 1'b1;
        i_reg_addr  = a;
        i_reg_wdata = d;
        tick(1);
        i_reg_wr    = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        tick(1);
        i_reg_addr = a;
        #1;
        d = o_reg_rdata;
    endtask : rd

    // waits for the new mode with a bounded count, watching ramp and flush on the way
    task automatic set_mode(input logic [7:0] code, input dcsm_mode_t exp, input logic rmp, input logic fls);
        int   n;
        logic saw_ramp;
        logic saw_flush;
        n         = 0;
        saw_ramp  = 1'b0;
        saw_flush = 1'b0;
        wr(DCSM_MODE_SEL_OFS, {8'h00, code});
        while (n < 100 && !(o_active_mode === exp && o_mode_busy === 1'b0)) begin
            tick(1);
            saw_ramp  = saw_ramp | (o_ramp_stop === 1'b1);
            saw_flush = saw_flush | (o_flush_pos === 1'b1);
            n++;
        end
        repeat (2) begin
            tick(1);
            saw_flush = saw_flush | (o_flush_pos === 1'b1);
        end
        chk("active_mode", 16'(exp), 16'(o_active_mode));
        chk("ramp_seen", 16'(rmp), 16'(saw_ramp));
        chk("flush_seen", 16'(fls), 16'(saw_flush));
        if (rmp) chk("ramp_wait", 16'h0001, 16'(n > int'(stop_delay)));
    endtask : set_mode

    logic [7:0] codes [10] = '{8'h01, 8'h06, 8'h08, 8'h03, 8'h04, 8'h09, 8'h0A, 8'h02, 8'h01, 8'h06};
    dcsm_mode_t modes [10] = '{DCSM_PROFILE_POSITION_MODE, DCSM_HOMING_MODE, DCSM_CYC_POS_MODE,
        DCSM_PROFILE_VELOCITY_MODE, DCSM_PROFILE_TORQUE_MODE, DCSM_CYC_VEL_MODE, DCSM_CYC_TRQ_MODE,
        DCSM_MODE_IDLE, DCSM_PROFILE_POSITION_MODE, DCSM_HOMING_MODE};
    logic [9:0] ramps   = 10'b0000111100;
    logic [9:0] flushes = 10'b0101000001;
    // state word position of each flag, indexed by flag struct bit
    int         pos [14] = '{15, 12, 13, 11, 10, 9, 7, 6, 5, 4, 3, 2, 1, 0};

    initial begin
        i_rst_n = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_addr = 16'h0000;
        i_reg_wdata = 16'h0000;
        i_flags = '0;
        i_drive_failure = 1'b0;
        homing_run = 1'b0;
        stop_delay = 8'h01;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        tick(2);
        i_rst_n = 1'b1;
        chk("reset_state", 16'h0000, o_state_word);
        chk("reset_mode", 16'(DCSM_MODE_IDLE), 16'(o_active_mode));
        // command decode: bits 10-15 set must not leak, mode bits pass through
        wr(DCSM_CMD_WORD_OFS, 16'hFE5B);
        tick(1);
        chk("req_decode", 16'h034D, 16'(o_req));
        chk("mode_bits", 16'h000D, 16'(o_req.mode_bits));
        rd(DCSM_CMD_WORD_OFS, rdat);
        chk("cmd_readback", 16'hFE5B, rdat);
        wr(DCSM_CMD_WORD_OFS, 16'h0100);
        tick(1);
        chk("req_halt", 16'h0010, 16'(o_req));
        $display("test command decode done");
        wr(DCSM_CMD_WORD_OFS, 16'h008F);
        tick(1);
        chk("fault_reset_pulse", 16'h0001, 16'(o_req.fault_reset));
        tick(1);
        chk("req_blocked", 16'h0000, 16'(o_req));
        wr(DCSM_CMD_WORD_OFS, 16'h008F);
        tick(2);
        chk("no_second_reset", 16'h0000, 16'(o_req));
        wr(DCSM_CMD_WORD_OFS, 16'h000F);
        tick(1);
        chk("req_after_release", 16'h03C0, 16'(o_req));
        $display("test fault reset edge done");
        for (int i = 0; i < 14; i++) begin
            i_flags = dcsm_flags_t'(14'h0001 << i);
            tick(2);
            chk("state_bit", 16'h0001 << pos[i], o_state_word);
        end
        i_flags = '1;
        tick(2);
        rd(DCSM_STATE_WORD_OFS, rdat);
        chk("state_all", 16'hBEFF, rdat);
        i_flags = '0;
        $display("test state word done");
        // cyclic modes entered with the drive not running, so no settle wait applies
        for (int i = 0; i < 10; i++) begin
            stop_delay = (i % 2 == 1) ? 8'h0C : 8'h01;
            set_mode(codes[i], modes[i], ramps[9 - i], flushes[9 - i]);
        end
        homing_run = 1'b1;
        wr(DCSM_MODE_SEL_OFS, 16'h0001);
        tick(10);
        chk("homing_hold", 16'(DCSM_HOMING_MODE), 16'(o_active_mode));
        chk("homing_busy", 16'h0001, 16'(o_mode_busy));
        homing_run = 1'b0;
        set_mode(8'h01, DCSM_PROFILE_POSITION_MODE, 1'b0, 1'b0);
        rd(DCSM_MODE_SEL_OFS, rdat);
        chk("mode_readback", 16'h0001, rdat);
        rd(16'h1234, rdat);
        chk("unmapped", 16'h0000, rdat);
        // cyclic velocity from a position mode: flush, no ramp
        set_mode(8'h09, DCSM_CYC_VEL_MODE, 1'b0, 1'b1);
        $display("test mode switching done");
        i_drive_failure = 1'b1;
        for (int n = 0; n < 8 && o_fault_shutdown !== 1'b1; n++) tick(1);
        chk("fault_shutdown", 16'h0001, 16'(o_fault_shutdown));
        tick(1);
        chk("shutdown_pattern", 16'h021F, {6'h00, o_state_word[9:0]});
        i_drive_failure = 1'b0;
        i_flags.fault = 1'b1;
        wr(DCSM_CMD_WORD_OFS, 16'h0000);
        wr(DCSM_CMD_WORD_OFS, 16'h0080);
        for (int n = 0; n < 8 && o_fault_shutdown !== 1'b0; n++) tick(1);
        chk("shutdown_cleared", 16'h0000, 16'(o_fault_shutdown));
        $display("test fault shutdown done");
        test_done();
    end
endmodule : tb
